// >>> hw/fmc_counter_a.sv
// Overview of operation
// - Sixteen-bit down-counter reloads from sixteen-bit latch
// - Modes needing a line take port bit four
// - High byte and both low aliases readable anytime
// - Low read clears flag; alias read does not
// - Latch byte writes leave running count alone
// - Transfer write loads high latch and counter in the same cycle
// - Decrement from zero reloads latch, sets flag
// - Flag cleared by low read, transfer, reset
// - Two low mode bits select four modes
// - Reset selects interval timer mode
// - Clock counting except event mode counts edges
// - Interval mode decrements once every clock
// - Flag with enable raises interrupt request
// - Interval mode leaves pin as port bit
// - Pulse mode toggles pin on underflow, transfer
// - Pulse entry drives high; transfer inverts the pin
// - Event mode counts rising edges, at most one per four clocks
// - Width mode counts while low, holds high
// - Width mode reloads at zero, keeps counting
// - New low period resumes from held count
// - Serial clock need forces internal-rate counting
// - Serial tick every sixteenth underflow, interval forced
//
// The AXI4-Lite interface to the registers was decided locally.
module fmc_counter_a
  import fmc_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic port_a_bit_four_level,
  output logic port_a_bit_four_drive,
  output logic port_a_bit_four_oe_n,
  input wire logic port_bit_data,
  input wire logic port_bit_enable,
  input wire logic serial_clock_needed,
  output logic serial_bit_tick,
  output logic underflow_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] latch;
    logic flag;
    logic irq_en;
    fmc_mode_e mode;
    fmc_mode_e eff_prev;
    logic pin_out;
    logic [2:0] sync;
    logic level;
    logic [SER_DIV_W-1:0] ser_div;
    logic ser_tick;
    logic irq;
    logic pa4_out;
    logic pa4_oe_n;
    logic aw_have;
    logic [ADDR_W-1:0] awaddr;
    logic w_have;
    logic [7:0] wbyte;
    logic wen;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } fmc_state_s;

  fmc_state_s s_q;
  fmc_state_s s_d;

  // Word decode shared by the read and write paths
  function automatic fmc_reg_e fmc_decode(input logic [ADDR_W-1:0] addr);
    fmc_reg_e r;
    r = FMC_REG_NONE;
    if (addr[1:0] == 2'h0) begin
      unique case (addr[ADDR_W-1:2])
        IDX_LOW: r = FMC_REG_LOW;
        IDX_HIGH: r = FMC_REG_HIGH;
        IDX_XFER: r = FMC_REG_XFER;
        IDX_MODE: r = FMC_REG_MODE;
        IDX_STAT: r = FMC_REG_STAT;
        default: r = FMC_REG_NONE;
      endcase
    end
    return r;
  endfunction

  logic edge_ok;
  logic rise;
  logic tick;
  logic underflow;
  logic load;
  logic do_wr;
  logic do_rd;
  fmc_reg_e wreg;
  fmc_reg_e rreg;
  fmc_mode_e eff;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    s_d = s_q;

    // Three-stage pin synchroniser; a change counts once stages two and three agree
    s_d.sync = {s_q.sync[1:0], port_a_bit_four_level};
    edge_ok = (s_q.sync[1] == s_q.sync[2]);
    if (edge_ok) begin
      s_d.level = s_q.sync[2];
    end
    rise = edge_ok && s_q.sync[2] && !s_q.level;

    // Serial use overrides the programmed mode with plain interval counting
    eff = serial_clock_needed ? FMC_INTERVAL : s_q.mode;

    // Count enable per mode
    unique case (eff)
      FMC_INTERVAL: tick = 1'b1;
      FMC_PULSE: tick = 1'b1;
      FMC_EVENT: tick = rise;
      FMC_WIDTH: tick = !s_q.level;
    endcase

    // Bus transactions that act this cycle
    do_wr = s_q.aw_have && s_q.w_have && !s_q.bvalid;
    wreg = fmc_decode(s_q.awaddr);
    do_rd = arvalid && s_q.arready;
    rreg = fmc_decode(araddr);
    load = do_wr && s_q.wen && (wreg == FMC_REG_XFER);

    // Latch and mode writes; the running count is untouched by latch bytes
    if (do_wr && s_q.wen) begin
      unique case (wreg)
        FMC_REG_LOW: s_d.latch[7:0] = s_q.wbyte;
        FMC_REG_HIGH: s_d.latch[15:8] = s_q.wbyte;
        FMC_REG_XFER: s_d.latch[15:8] = s_q.wbyte;
        FMC_REG_MODE: begin
          s_d.mode = fmc_mode_e'(s_q.wbyte[MODE_SEL_LSB +: 2]);
          s_d.irq_en = s_q.wbyte[MODE_IRQ_EN_BIT];
        end
        default: begin
        end
      endcase
    end

    // Counter: transfer beats counting; zero reloads instead of wrapping
    underflow = tick && !load && (s_q.count == '0);
    if (load) begin
      s_d.count = {s_q.wbyte, s_q.latch[7:0]};
    end else if (underflow) begin
      s_d.count = s_q.latch;
    end else if (tick) begin
      s_d.count = s_q.count - 16'h0001;
    end

    // Underflow flag; a set in the same cycle as a clear wins
    s_d.flag = underflow || (s_q.flag && !(load || (do_rd && rreg == FMC_REG_LOW)));
    s_d.irq = s_d.flag && s_d.irq_en;

    // Bit-rate divider runs only while the serial channel needs a clock
    s_d.ser_tick = 1'b0;
    if (!serial_clock_needed) begin
      s_d.ser_div = '0;
    end else if (underflow) begin
      if (s_q.ser_div == SER_DIV_LAST) begin
        s_d.ser_div = '0;
        s_d.ser_tick = 1'b1;
      end else begin
        s_d.ser_div = s_q.ser_div + 4'h1;
      end
    end

    // Pulse output: high on entry, then toggled by underflow or transfer
    if (eff == FMC_PULSE && s_q.eff_prev != FMC_PULSE) begin
      s_d.pin_out = 1'b1;
    end else if (eff == FMC_PULSE && (underflow || load)) begin
      s_d.pin_out = !s_q.pin_out;
    end
    s_d.eff_prev = eff;

    // Pin ownership: port logic in interval mode, counter otherwise
    unique case (eff)
      FMC_INTERVAL: begin
        s_d.pa4_out = port_bit_data;
        s_d.pa4_oe_n = !port_bit_enable;
      end
      FMC_PULSE: begin
        s_d.pa4_out = s_d.pin_out;
        s_d.pa4_oe_n = 1'b0;
      end
      default: begin
        s_d.pa4_out = 1'b1;
        s_d.pa4_oe_n = 1'b1;
      end
    endcase

    // Read channel; reads sample the live count
    if (s_q.rvalid && rready) begin
      s_d.rvalid = 1'b0;
    end
    if (do_rd) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = RESP_OKAY;
      s_d.rdata = '0;
      unique case (rreg)
        FMC_REG_LOW: s_d.rdata[7:0] = s_q.count[7:0];
        FMC_REG_XFER: s_d.rdata[7:0] = s_q.count[7:0];
        FMC_REG_HIGH: s_d.rdata[7:0] = s_q.count[15:8];
        FMC_REG_MODE: begin
          s_d.rdata[MODE_SEL_LSB +: 2] = s_q.mode;
          s_d.rdata[MODE_IRQ_EN_BIT] = s_q.irq_en;
        end
        FMC_REG_STAT: begin
          s_d.rdata[STAT_FLAG_BIT] = s_q.flag;
          s_d.rdata[STAT_PIN_BIT] = s_q.pin_out;
          s_d.rdata[STAT_LEVEL_BIT] = s_q.level;
        end
        default: s_d.rresp = RESP_SLVERR;
      endcase
    end
    s_d.arready = !s_d.rvalid; // One read in flight keeps the read path trivial

    // Write channel: address and data are taken in either order
    if (awvalid && s_q.awready) begin
      s_d.aw_have = 1'b1;
      s_d.awaddr = awaddr;
    end
    if (wvalid && s_q.wready) begin
      s_d.w_have = 1'b1;
      s_d.wbyte = wdata[7:0];
      s_d.wen = wstrb[0];
    end
    if (s_q.bvalid && bready) begin
      s_d.bvalid = 1'b0;
    end
    if (do_wr) begin
      s_d.aw_have = 1'b0;
      s_d.w_have = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = (wreg == FMC_REG_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
    s_d.awready = !s_d.aw_have && !s_d.bvalid;
    s_d.wready = !s_d.w_have && !s_d.bvalid;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  // Reset leaves the bus ready one cycle after release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.count <= COUNT_RST;
      s_q.latch <= LATCH_RST;
      s_q.mode <= FMC_INTERVAL;
      s_q.eff_prev <= FMC_INTERVAL;
      s_q.sync <= SYNC_RST;
      s_q.level <= 1'b1;
      s_q.pin_out <= 1'b1;
      s_q.pa4_out <= 1'b1;
      s_q.pa4_oe_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Every output is a flop of the state
  assign awready = s_q.awready;
  assign wready = s_q.wready;
  assign bresp = s_q.bresp;
  assign bvalid = s_q.bvalid;
  assign arready = s_q.arready;
  assign rdata = s_q.rdata;
  assign rresp = s_q.rresp;
  assign rvalid = s_q.rvalid;
  assign port_a_bit_four_drive = s_q.pa4_out;
  assign port_a_bit_four_oe_n = s_q.pa4_oe_n;
  assign serial_bit_tick = s_q.ser_tick;
  assign underflow_irq = s_q.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Reset always lands in interval mode
  a_reset_mode: assert property (@(posedge aclk) disable iff (1'b0) !aresetn |=> s_q.mode == FMC_INTERVAL)
    else $error("mode not interval after reset");

  // Free-running decrement by exactly one
  a_interval_step: assert property (
    (eff == FMC_INTERVAL && !load && s_q.count != '0) |=> s_q.count == $past(s_q.count) - 16'h0001)
    else $error("interval step not one");

  // Zero reloads from the latch and raises the flag
  a_underflow_reload: assert property (
    (aresetn && underflow) |=> (s_q.count == $past(s_q.latch)) && s_q.flag)
    else $error("underflow did not reload");

  // Transfer loads high byte plus low latch and clears the flag
  a_transfer_load: assert property (
    load |=> (s_q.count == {$past(s_q.wbyte), $past(s_q.latch[7:0])}) && !s_q.flag)
    else $error("transfer load wrong");

  // Low read clears the flag unless an underflow lands
  a_low_read_clear: assert property (
    (do_rd && rreg == FMC_REG_LOW && !underflow) |=> !s_q.flag)
    else $error("low read kept flag");

  // Alias read leaves the flag set
  a_alias_read_keep: assert property (
    (do_rd && rreg == FMC_REG_XFER && s_q.flag && !load) |=> s_q.flag)
    else $error("alias read cleared flag");

  // Width mode holds while the line is high
  a_width_hold: assert property (
    (eff == FMC_WIDTH && s_q.level && !load) |=> $stable(s_q.count))
    else $error("width count moved while high");

  // Event mode moves only on a rising edge
  a_event_idle: assert property (
    (eff == FMC_EVENT && !rise && !load) |=> $stable(s_q.count))
    else $error("event count moved without edge");

  // Pulse output inverts on underflow or transfer
  a_pulse_toggle: assert property (
    (eff == FMC_PULSE && s_q.eff_prev == FMC_PULSE && (underflow || load))
      |=> port_a_bit_four_drive != $past(port_a_bit_four_drive))
    else $error("pulse output did not toggle");

  // Input modes release the pin
  a_pin_released: assert property (
    (eff == FMC_EVENT || eff == FMC_WIDTH) |=> port_a_bit_four_oe_n)
    else $error("pin driven in input mode");

  // Interrupt tracks flag and enable
  a_irq_follow: assert property (
    (s_q.flag && s_q.irq_en) |-> underflow_irq)
    else $error("interrupt missing");

  c_pulse_underflow: cover property (eff == FMC_PULSE && underflow);
  c_event_edge: cover property (eff == FMC_EVENT && rise);
  c_width_reload: cover property (eff == FMC_WIDTH && underflow);
  c_serial_tick: cover property (s_q.ser_tick);

endmodule

// >>> hw/fmc_pkg.sv
package fmc_pkg;

  // Counter geometry
  localparam int CNT_W = 16;

  // Register indices; the byte address is four times the index
  localparam logic [5:0] IDX_LOW = 6'h18;
  localparam logic [5:0] IDX_HIGH = 6'h19;
  localparam logic [5:0] IDX_XFER = 6'h1a;
  localparam logic [5:0] IDX_MODE = 6'h1b;
  localparam logic [5:0] IDX_STAT = 6'h1c;

  // Field positions in the mode and status registers
  localparam int MODE_SEL_LSB = 0;
  localparam int MODE_IRQ_EN_BIT = 2;
  localparam int STAT_FLAG_BIT = 0;
  localparam int STAT_PIN_BIT = 1;
  localparam int STAT_LEVEL_BIT = 2;

  // Reset values
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] LATCH_RST = 16'h0000;
  localparam logic [2:0] SYNC_RST = 3'h7;

  // Serial bit clock is one sixteenth of the underflow rate
  localparam int SER_DIV_W = 4;
  localparam logic [3:0] SER_DIV_LAST = 4'hf;

  // Bus response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Counter modes, in the order of their two-bit codes
  typedef enum logic [1:0] {
    FMC_INTERVAL,
    FMC_PULSE,
    FMC_EVENT,
    FMC_WIDTH
  } fmc_mode_e;

  // Decoded register targets
  typedef enum logic [2:0] {
    FMC_REG_LOW,
    FMC_REG_HIGH,
    FMC_REG_XFER,
    FMC_REG_MODE,
    FMC_REG_STAT,
    FMC_REG_NONE
  } fmc_reg_e;

endpackage

// >>> testbench/fmc_pin_src.sv
module fmc_pin_src (
  input wire logic aclk,
  input wire logic go,
  input wire logic [7:0] low_len,
  input wire logic [7:0] pulses,
  output logic level,
  output logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] left_q = 8'h00;
  logic [7:0] cyc_q = 8'h00;
  logic level_q = 1'b1;
  logic busy_q = 1'b0;
  assign level = level_q;
  assign busy = busy_q;
  // Low phases then three high cycles: edges never come faster than half the clock
  always @(posedge aclk) begin
    if (go && !busy_q) begin
      busy_q <= 1'b1;
      left_q <= pulses;
      cyc_q <= 8'h00;
      level_q <= 1'b0;
    end else if (busy_q && cyc_q == low_len + 8'h02) begin
      // Pulse done: start the next low, or rest high as with a pull-up
      cyc_q <= 8'h00;
      left_q <= left_q - 8'h01;
      busy_q <= (left_q != 8'h01);
      level_q <= (left_q == 8'h01);
    end else if (busy_q) begin
      cyc_q <= cyc_q + 8'h01;
      level_q <= (cyc_q + 8'h01 >= low_len);
    end
  end
endmodule

// >>> testbench/fmc_counter_a_tb.sv
module fmc_counter_a_tb
  import fmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, llen = 8'h00, npulse = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, drive, oe_n, tick, irq, src, busy, pin;
  logic [1:0] bresp, rresp;
  logic pdata = 1'b1, pen = 1'b0, scn = 1'b0, go = 1'b0;
  int fails = 0;
  int cmp_count = 0;
  // Wire level: the block wins while it drives, else the source
  assign pin = oe_n ? src : drive;
  always #5 aclk = ~aclk;
  fmc_counter_a #(.ADDR_W(8)) dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .port_a_bit_four_level(pin), .port_a_bit_four_drive(drive), .port_a_bit_four_oe_n(oe_n),
    .port_bit_data(pdata), .port_bit_enable(pen), .serial_clock_needed(scn), .serial_bit_tick(tick),
    .underflow_irq(irq));
  fmc_pin_src u_src (.aclk, .go, .low_len(llen), .pulses(npulse), .level(src), .busy);
  ////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("compares=%0d mismatches=%0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Bus master: each channel held until its own ready edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, {24'h0, e});
    chk({30'h0, r}, {30'h0, RESP_OKAY});
  endtask
  task automatic flag_is(input logic e);
    logic [31:0] d;
    logic [1:0] r;
    rd(8'h70, d, r);
    chk({31'h0, d[0]}, {31'h0, e});
    chk({31'h0, irq}, {31'h0, e});
  endtask
  task automatic pulses(input logic [7:0] n, input logic [7:0] l);
    @(posedge aclk);
    llen <= l;
    npulse <= n;
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    repeat (2) @(posedge aclk);
    while (busy) @(posedge aclk);
    repeat (6) @(posedge aclk); // Let the pin synchroniser settle
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Latch of zero reloads zero, never all ones
  task automatic t_reset;
    rc(8'h6c, 8'h00);
    rc(8'h64, 8'h00);
    rc(8'h68, 8'h00);
  endtask
  // Load, high-latch write mid-run, underflow, flag clearing
  task automatic t_load;
    logic [31:0] d;
    logic [1:0] r;
    wr(8'h6c, 8'h04, RESP_OKAY);
    wr(8'h60, 8'h30, RESP_OKAY);
    wr(8'h68, 8'h00, RESP_OKAY);
    wr(8'h64, 8'hff, RESP_OKAY);
    rc(8'h64, 8'h00);
    rc(8'h68, 8'h27);
    repeat (60) @(posedge aclk);
    flag_is(1'b1);
    rc(8'h64, 8'hff);
    rd(8'h68, d, r);
    flag_is(1'b1);
    rd(8'h60, d, r);
    flag_is(1'b0);
  endtask
  // Pulse output: high on entry, toggles on transfer and each underflow
  task automatic t_pulse;
    int n;
    logic p;
    n = 0;
    wr(8'h6c, 8'h01, RESP_OKAY);
    #1;
    chk({30'h0, oe_n, drive}, 32'h1);
    wr(8'h60, 8'h03, RESP_OKAY);
    wr(8'h68, 8'h00, RESP_OKAY);
    #1;
    chk({31'h0, drive}, 32'h0);
    p = drive;
    repeat (40) begin
      @(posedge aclk);
      #1;
      n += (drive != p);
      p = drive;
    end
    chk(n, 32'h0000000a);
  endtask
  // Interval mode hands the pin back to the port logic
  task automatic t_port;
    wr(8'h6c, 8'h00, RESP_OKAY);
    pen <= 1'b1;
    pdata <= 1'b0;
    repeat (3) @(posedge aclk);
    chk({30'h0, oe_n, drive}, 32'h0);
    pen <= 1'b0;
    pdata <= 1'b1;
    repeat (3) @(posedge aclk);
    chk({30'h0, oe_n, drive}, 32'h3);
  endtask
  // Event mode counts only rising edges on the pin
  task automatic t_event;
    wr(8'h6c, 8'h02, RESP_OKAY);
    wr(8'h60, 8'h00, RESP_OKAY);
    wr(8'h68, 8'h10, RESP_OKAY);
    chk({31'h0, oe_n}, 32'h1);
    pulses(8'h05, 8'h03);
    rc(8'h64, 8'h0f);
    rc(8'h68, 8'hfb);
  endtask
  // Width mode: low periods add up, highs hold, zero reloads and keeps counting
  task automatic t_width;
    wr(8'h6c, 8'h07, RESP_OKAY);
    wr(8'h68, 8'h10, RESP_OKAY);
    pulses(8'h02, 8'h0a);
    rc(8'h64, 8'h0f);
    rc(8'h68, 8'hec);
    wr(8'h60, 8'h04, RESP_OKAY);
    wr(8'h68, 8'h00, RESP_OKAY);
    wr(8'h64, 8'h10, RESP_OKAY);
    pulses(8'h01, 8'h08);
    rc(8'h64, 8'h10);
    rc(8'h68, 8'h01);
    flag_is(1'b1);
  endtask
  // Serial demand forces clock counting; tick every sixteenth underflow
  task automatic t_serial;
    int n;
    n = 0;
    scn <= 1'b1;
    wr(8'h60, 8'h00, RESP_OKAY);
    wr(8'h68, 8'h00, RESP_OKAY);
    repeat (64) begin
      @(posedge aclk);
      n += tick;
    end
    chk(n, 32'h00000004);
    scn <= 1'b0;
  endtask
  // Unmapped or misaligned places are refused; a write with no strobe has no effect
  task automatic t_bad;
    logic [31:0] d;
    logic [1:0] r;
    rd(8'h74, d, r);
    chk({r, d[29:0]}, {RESP_SLVERR, 30'h0});
    rd(8'h62, d, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    wr(8'h74, 8'h5a, RESP_SLVERR);
    wstrb <= 4'h0;
    wr(8'h6c, 8'h01, RESP_OKAY);
    wstrb <= 4'hf;
    rc(8'h6c, 8'h07);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    fails++;
    summarize();
  end
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_load();
    t_pulse();
    t_port();
    t_event();
    t_width();
    t_serial();
    t_bad();
    summarize();
  end
endmodule
